// ### osl_code_reg.sv
/*
  quantizer from a pin-to-supply ratio sample to a 25 mV shift code, registered output.
  assumes the sample is already synchronised and ratiometric to the supply.
*/
`include "osl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module osl_code_reg
  import osl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic [7:0] ratio_i,
  output logic [5:0] code_o
);
  // ratio in 1/256 units; bin k spans centre (k+1)/32 +- 1/64
  wire logic below_zero = ratio_i < `OSL_ZERO_BINS;
  wire logic top_bin = ratio_i >= `OSL_TOP_BIN;
  wire logic [7:0] biased = ratio_i + 8'h04;
  wire logic [5:0] mid_code = {1'b0, biased[7:3]} - 6'd1;
  wire logic [5:0] code_nxt = below_zero ? 6'h00 : (top_bin ? `OSL_MAX_CODE : mid_code);
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      code_o <= 6'h00;
    else if (load_i)
      code_o <= code_nxt;
  end
endmodule
`default_nettype wire

// ### osl_far_model.sv
/*
  far-side model: offset dividers fed from the logic supply, rail current comparators.
  assumes the bench gives pin and supply levels in mV and load in percent of the first limit.
*/
`timescale 1ns/1ps
`default_nettype none
module osl_far_model
  import osl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [15:0] supply_mv_i,
  input wire logic [15:0] core_mv_i,
  input wire logic [15:0] aux_mv_i,
  input wire logic [7:0] load_pct_i,
  output logic [7:0] core_ratio_o,
  output logic [7:0] aux_ratio_o,
  output logic conv_valid_o,
  output var osl_cur_s cur_o
);
  // a pin tied to the supply reads full scale, so clip instead of wrapping
  function automatic logic [7:0] ratio(input logic [15:0] v, input logic [15:0] s);
    logic [23:0] q;
    q = {v, 8'h00} / s;
    return (q > 24'hFF) ? 8'hFF : q[7:0];
  endfunction
  always_ff @(posedge clk_sys_i)
  begin
    core_ratio_o <= ratio(core_mv_i, supply_mv_i);
    aux_ratio_o <= ratio(aux_mv_i, supply_mv_i);
    conv_valid_o <= 1'b1;
    cur_o.over_first <= load_pct_i > 8'h64;
    cur_o.over_second <= load_pct_i > 8'h82;
  end
endmodule
`default_nettype wire

// ### osl_map.svh
/*
  timing counts and field constants for the offset encoder and overcurrent latch.
  assumes a 40 MHz system clock; included by its bare name.
*/
`ifndef OSL_MAP_SVH
`define OSL_MAP_SVH
`define OSL_CLK_HZ 40000000
`define OSL_OCP_DELAY_MS 50
`define OSL_OCP_DELAY_CYC ((`OSL_CLK_HZ / 1000) * `OSL_OCP_DELAY_MS)
`define OSL_ADC_W 8
`define OSL_CODE_W 6
`define OSL_STEP_MV 25
`define OSL_MAX_CODE 6'h20
`define OSL_ZERO_BINS 8'h0C
`define OSL_TOP_BIN 8'hFC
`define OSL_BIN_SHIFT 3
`define OSL_LIMIT2_NUM 13
`define OSL_LIMIT2_DEN 10
`define OSL_ADDR_CTRL 12'h000
`define OSL_ADDR_STAT 12'h004
`define OSL_ADDR_IRQ 12'h008
`define OSL_ADDR_MASK 12'h00C
`define OSL_ADDR_SHIFT 12'h010
`define OSL_CTRL_RST 32'h0000_0000
`define OSL_STAT_LIM1 0
`define OSL_STAT_LIM2 1
`define OSL_STAT_LATCH 2
`endif

// ### osl_pkg.sv
/*
  types for the offset encoder and overcurrent latch.
  assumes osl_map.svh is available.
*/
package osl_pkg;
  typedef enum logic [5:0] {
    OSL_OFF = 6'b000001,
    OSL_PAR_SS = 6'b000010,
    OSL_PAR_RUN = 6'b000100,
    OSL_SER_SS = 6'b001000,
    OSL_SER_BOOT = 6'b010000,
    OSL_SER_RUN = 6'b100000
  } osl_phase_e;
  typedef struct packed {
    logic [5:0] core_code;
    logic [5:0] aux_code;
  } osl_shift_s;
  typedef struct packed {
    logic over_first;
    logic over_second;
  } osl_cur_s;
endpackage

// ### osl_props.sv
/*
  port assertions for the offset encoder and overcurrent latch.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module osl_props #(
  parameter int OCP_DELAY_CYC = 50
)
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic first_current_limit_i,
  input wire logic second_current_limit_i,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pwm_hiz_o,
  input wire logic aux_rail_on_o,
  input wire logic [5:0] core_shift_code_o,
  input wire logic [5:0] aux_shift_code_o,
  input wire logic irq_o
);
  int lim1_cnt;
  // counts cycles of first-limit overload while enabled; margin covers the sync stages
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i || !first_current_limit_i || !enable_i)
      lim1_cnt <= 0;
    else if (lim1_cnt < OCP_DELAY_CYC + 9)
      lim1_cnt <= lim1_cnt + 1;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // ----------------
  // checks
  // ----------------
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_err: assert property (pready && (paddr > 12'h010 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("no error on unmapped access");
  a_mapped_ok: assert property (pready && paddr <= 12'h010 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped access");
  a_code_range: assert property (core_shift_code_o <= 6'h20 && aux_shift_code_o <= 6'h20)
    else $error("shift code above full scale");
  a_aux_off_zero: assert property (!aux_rail_on_o |-> aux_shift_code_o == 6'h00)
    else $error("aux shift with aux rail off");
  a_hiz_second: assert property ($rose(second_current_limit_i) && enable_i |-> ##[1:4] pwm_hiz_o)
    else $error("second limit did not float outputs");
  a_lim1_latch: assert property (lim1_cnt == OCP_DELAY_CYC + 6 |-> pwm_hiz_o)
    else $error("first limit did not latch");
  c_hiz: cover property ($rose(pwm_hiz_o));
  c_irq: cover property ($rose(irq_o));
  c_err: cover property (pready && pslverr);
endmodule
bind osl_top osl_props #(.OCP_DELAY_CYC(OCP_DELAY_CYC)) props (.clk_sys_i, .reset_n_i, .enable_i,
  .first_current_limit_i, .second_current_limit_i, .paddr, .psel, .penable, .pready, .pslverr,
  .pwm_hiz_o, .aux_rail_on_o, .core_shift_code_o, .aux_shift_code_o, .irq_o);
`default_nettype wire

// ### osl_top.sv
/*
  offset shift encoder and two-stage overcurrent latch of a multiphase controller.
  assumes comparator levels and the converter samples arrive asynchronously from analog;
  software reaches control and status over APB.
*/
// How it works
// - first limit latches after 50 ms persistence
// - second limit latches high-impedance immediately
// - 0 to 800 mV shift per rail
// - 25 mV bins, zero below, top 800
// - aux pin uses same shared converter table
// - converter referenced to logic supply ratio
// - parallel soft-start: no core shift, aux off
// - normal: core shift; serial adds aux
// - serial soft-start: no shifts, aux on
// - serial boot hold: no shifts
// - fixed test mode: no shifts
`include "osl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module osl_top
  import osl_pkg::*;
#(
  parameter int OCP_DELAY_CYC = `OSL_OCP_DELAY_CYC
)
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic first_current_limit_i,
  input wire logic second_current_limit_i,
  input wire logic [7:0] core_ratio_i,
  input wire logic [7:0] aux_shift_pin_i,
  input wire logic conv_valid_i,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic conv_sel_aux_o,
  output logic pwm_hiz_o,
  output logic drv_on_o,
  output logic aux_rail_on_o,
  output logic [5:0] core_shift_code_o,
  output logic [5:0] aux_shift_code_o,
  output logic irq_o
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] lim1_sync_r;
  logic [1:0] lim2_sync_r;
  logic [1:0] en_sync_r;
  logic [1:0] cv_sync_r;
  logic [7:0] core_s1_r;
  logic [7:0] core_s2_r;
  logic [7:0] aux_s1_r;
  logic [7:0] aux_s2_r;
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      lim1_sync_r <= 2'h0;
      lim2_sync_r <= 2'h0;
      en_sync_r <= 2'h0;
      cv_sync_r <= 2'h0;
      core_s1_r <= 8'h00;
      core_s2_r <= 8'h00;
      aux_s1_r <= 8'h00;
      aux_s2_r <= 8'h00;
    end
    else
    begin
      lim1_sync_r <= {lim1_sync_r[0], first_current_limit_i};
      lim2_sync_r <= {lim2_sync_r[0], second_current_limit_i};
      en_sync_r <= {en_sync_r[0], enable_i};
      cv_sync_r <= {cv_sync_r[0], conv_valid_i};
      core_s1_r <= core_ratio_i;
      core_s2_r <= core_s1_r;
      aux_s1_r <= aux_shift_pin_i;
      aux_s2_r <= aux_s1_r;
    end
  end
  osl_cur_s cur;
  assign cur.over_first = lim1_sync_r[1];
  assign cur.over_second = lim2_sync_r[1];
  wire logic en_ok = en_sync_r[1];
  // multi-bit ratio words are only used while the converter says valid, so bit skew settles
  wire logic cv_ok = cv_sync_r[1];

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite && pready;
  wire logic hit_ctrl = paddr == `OSL_ADDR_CTRL;
  wire logic hit_stat = paddr == `OSL_ADDR_STAT;
  wire logic hit_irq = paddr == `OSL_ADDR_IRQ;
  wire logic hit_mask = paddr == `OSL_ADDR_MASK;
  wire logic hit_shift = paddr == `OSL_ADDR_SHIFT;
  wire logic hit_any = hit_ctrl || hit_stat || hit_irq || hit_mask || hit_shift;
  // ctrl: [0] serial mode, [1] fixed test mode, [2] soft-start done, [3] boot hold done
  wire logic serial_mode = ctrl_r[0];
  wire logic fixed_voltage_test_mode = ctrl_r[1];
  wire logic ss_done = ctrl_r[2];
  wire logic boot_done = ctrl_r[3];

  // ----------------------------------------------------------------
  // overcurrent latch
  // ----------------------------------------------------------------
  logic [31:0] ocp_cnt_r;
  logic latch_r;
  wire logic clear_all = !en_ok;
  wire logic cnt_done = ocp_cnt_r >= 32'(OCP_DELAY_CYC - 1);
  // the count holds at the limit, so a long overload cannot wrap and lose the trip
  wire logic trip_first = cur.over_first && !cur.over_second && cnt_done;
  wire logic trip_second = cur.over_second;
  wire logic [31:0] cnt_nxt = (clear_all || !cur.over_first) ? 32'h0 :
                              (cnt_done ? ocp_cnt_r : ocp_cnt_r + 32'h1);
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      ocp_cnt_r <= 32'h0;
    else
      ocp_cnt_r <= cnt_nxt;
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      latch_r <= 1'b0;
    else if (clear_all)
      latch_r <= 1'b0;
    else if (trip_first || trip_second)
      latch_r <= 1'b1;
  end
  // second limit drives high-impedance combinationally off the sync, no extra stage
  wire logic hiz_nxt = latch_r || trip_second || !en_ok;

  // ----------------------------------------------------------------
  // operating phase
  // ----------------------------------------------------------------
  osl_phase_e phase_r;
  osl_phase_e phase_nxt;
  always_comb
  begin
    phase_nxt = phase_r;
    case (phase_r)
      OSL_OFF:
        if (en_ok && !latch_r)
          phase_nxt = serial_mode ? OSL_SER_SS : OSL_PAR_SS;
      OSL_PAR_SS:
        if (ss_done)
          phase_nxt = OSL_PAR_RUN;
      OSL_PAR_RUN:
        phase_nxt = OSL_PAR_RUN;
      OSL_SER_SS:
        if (ss_done)
          phase_nxt = OSL_SER_BOOT;
      OSL_SER_BOOT:
        if (boot_done)
          phase_nxt = OSL_SER_RUN;
      OSL_SER_RUN:
        phase_nxt = OSL_SER_RUN;
      default:
        phase_nxt = OSL_OFF;
    endcase
    // a fault or a low enable overrides every phase
    if (!en_ok || latch_r)
      phase_nxt = OSL_OFF;
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      phase_r <= OSL_OFF;
    else
      phase_r <= phase_nxt;
  end

  // ----------------------------------------------------------------
  // shared converter, one pin per sample
  // ----------------------------------------------------------------
  logic sel_aux_r;
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      sel_aux_r <= 1'b0;
    else if (cv_ok)
      sel_aux_r <= !sel_aux_r;
  end
  // samples are ratios to the logic supply, so no absolute reference enters here
  wire logic [7:0] conv_in = sel_aux_r ? aux_s2_r : core_s2_r;
  logic [5:0] conv_code;
  osl_code_reg u_code
  (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .load_i(cv_ok),
    .ratio_i(conv_in),
    .code_o(conv_code)
  );
  logic dst_aux_r;
  logic ld_r;
  osl_shift_s raw_r;
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      dst_aux_r <= 1'b0;
      ld_r <= 1'b0;
      raw_r <= '0;
    end
    else
    begin
      dst_aux_r <= sel_aux_r;
      ld_r <= cv_ok;
      if (ld_r && dst_aux_r)
        raw_r.aux_code <= conv_code;
      else if (ld_r)
        raw_r.core_code <= conv_code;
    end
  end

  // ----------------------------------------------------------------
  // shift gating per phase
  // ----------------------------------------------------------------
  wire logic core_allow = !fixed_voltage_test_mode &&
                          (phase_r == OSL_PAR_RUN || phase_r == OSL_SER_RUN);
  // aux shift drops with the rail, so no aux offset outlives a fault or a disable
  wire logic aux_allow = !fixed_voltage_test_mode && phase_r == OSL_SER_RUN &&
                         !hiz_nxt;
  wire logic aux_on_nxt = phase_r == OSL_SER_SS || phase_r == OSL_SER_BOOT ||
                          phase_r == OSL_SER_RUN;
  wire logic [5:0] core_out_nxt = core_allow ? raw_r.core_code : 6'h00;
  wire logic [5:0] aux_out_nxt = aux_allow ? raw_r.aux_code : 6'h00;
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      core_shift_code_o <= 6'h00;
      aux_shift_code_o <= 6'h00;
      aux_rail_on_o <= 1'b0;
      pwm_hiz_o <= 1'b1;
      drv_on_o <= 1'b0;
      conv_sel_aux_o <= 1'b0;
    end
    else
    begin
      core_shift_code_o <= core_out_nxt;
      aux_shift_code_o <= aux_out_nxt;
      aux_rail_on_o <= aux_on_nxt && !hiz_nxt;
      pwm_hiz_o <= hiz_nxt;
      drv_on_o <= !hiz_nxt && phase_r != OSL_OFF;
      conv_sel_aux_o <= sel_aux_r;
    end
  end

  // ----------------------------------------------------------------
  // interrupts and bus
  // ----------------------------------------------------------------
  logic over_first_q;
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      over_first_q <= 1'b0;
    else
      over_first_q <= cur.over_first;
  end
  wire logic [2:0] ev_set = {trip_first || trip_second, trip_second, cur.over_first && !over_first_q};
  // a one written clears its bit, a zero leaves it alone
  wire logic [2:0] w1c = (wr && hit_irq) ? pwdata[2:0] : 3'h0;
  wire logic [2:0] irq_nxt;
  // set wins over a same-cycle write-one clear, so a fault is never lost to a late handler
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_irq
      assign irq_nxt[gi] = (irq_stat_r[gi] && !w1c[gi]) || ev_set[gi];
    end
  endgenerate

  wire logic [31:0] stat_word = {26'h0, phase_r == OSL_OFF, aux_on_nxt, latch_r,
                                 1'b0, cur.over_second, cur.over_first};
  wire logic [31:0] shift_word = {20'h0, raw_r.aux_code, raw_r.core_code};
  wire logic [31:0] rd_nxt = hit_ctrl ? ctrl_r :
                             hit_stat ? stat_word :
                             hit_irq ? {29'h0, irq_stat_r} :
                             hit_mask ? {29'h0, irq_mask_r} :
                             hit_shift ? shift_word : 32'h0;

  // a write lands only at the access edge that sees pready, so it is taken once
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      ctrl_r <= `OSL_CTRL_RST;
    else if (wr && hit_ctrl)
      ctrl_r <= {28'h0, pwdata[3:0]};
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      irq_mask_r <= 3'h0;
    else if (wr && hit_mask)
      irq_mask_r <= pwdata[2:0];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      irq_stat_r <= 3'h0;
      irq_o <= 1'b0;
    end
    else
    begin
      irq_stat_r <= irq_nxt;
      irq_o <= |(irq_nxt & irq_mask_r);
    end
  end

  // no wait state: pready answers the edge after setup, which lets prdata be a register
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !pready;
      pslverr <= psel && !pready && !hit_any;
      prdata <= rd_nxt;
    end
  end
endmodule
`default_nettype wire

// ### test_offset_encode_and_ocp_latch.sv
/*
  self-checking bench: modes, shift code table, two-stage overcurrent latch, irq.
  assumes osl_top, osl_far_model and the package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t value mismatch got %h exp %h", $time, g, e); end end
module test_offset_encode_and_ocp_latch
  import osl_pkg::*;
;
  localparam int OCP = 50;
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, enable_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic [15:0] supply = 16'd2560, core_mv = 16'h0, aux_mv = 16'h0;
  logic [7:0] load = 8'h00, core_ratio, aux_ratio;
  logic conv_valid, pwm_hiz_o, drv_on_o, aux_rail_on_o, irq_o, conv_sel_aux_o, sel_q;
  logic [5:0] core_shift_code_o, aux_shift_code_o;
  osl_cur_s cur;
  int miscompares = 0, num_checks = 0;
  // ctrl nibble, core applied, aux applied, aux rail on
  logic [6:0] mode_tab [7] = '{7'h00, 7'h24, 7'h09, 7'h29, 7'h6F, 7'h70, 7'h79};
  int rs [10] = '{0, 11, 12, 19, 20, 127, 128, 251, 252, 255};
  osl_far_model far (.clk_sys_i, .supply_mv_i(supply), .core_mv_i(core_mv), .aux_mv_i(aux_mv),
    .load_pct_i(load), .core_ratio_o(core_ratio), .aux_ratio_o(aux_ratio),
    .conv_valid_o(conv_valid), .cur_o(cur));
  osl_top #(.OCP_DELAY_CYC(OCP)) uut (.clk_sys_i, .reset_n_i, .enable_i,
    .first_current_limit_i(cur.over_first), .second_current_limit_i(cur.over_second),
    .core_ratio_i(core_ratio), .aux_shift_pin_i(aux_ratio), .conv_valid_i(conv_valid),
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .conv_sel_aux_o,
    .pwm_hiz_o, .drv_on_o, .aux_rail_on_o, .core_shift_code_o, .aux_shift_code_o, .irq_o);
  function automatic logic [5:0] code_of(input int r);
    return (r < 12) ? 6'h00 : (r >= 252) ? 6'h20 : 6'((r - 12) / 8 + 1);
  endfunction
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
    end
    while (pready !== 1'b1);
    rd_q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd_q, e)
  endtask
  // mode is taken when the block leaves off, so ctrl is written while disabled
  task automatic start(input logic [3:0] c);
    enable_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    xfer(1'b1, 12'h000, {28'h0, c});
    enable_i <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    test_done();
  end
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rd(12'h004, 32'h20);
    rd(12'h020, 32'h0);
    `CHK(err, 1'b1)
    core_mv <= 16'd2550;
    aux_mv <= 16'd2550;
    foreach (mode_tab[i])
    begin
      start(mode_tab[i][6:3]);
      `CHK(core_shift_code_o, mode_tab[i][2] ? 6'h20 : 6'h00)
      `CHK(aux_shift_code_o, mode_tab[i][1] ? 6'h20 : 6'h00)
      `CHK(aux_rail_on_o, mode_tab[i][0])
    end
    $display("mode test done");
    sel_q = conv_sel_aux_o;
    @(posedge clk_sys_i);
    `CHK(conv_sel_aux_o, !sel_q)
    start(4'hD);
    for (int s = 1; s <= 2; s++)
    begin
      foreach (rs[i])
      begin
        supply <= 16'(2560 * s);
        core_mv <= 16'(rs[i] * 10 * s);
        aux_mv <= 16'((255 - rs[i]) * 10 * s);
        repeat (10) @(posedge clk_sys_i);
        `CHK(core_shift_code_o, code_of(rs[i]))
        `CHK(aux_shift_code_o, code_of(255 - rs[i]))
        rd(12'h010, {20'h0, code_of(255 - rs[i]), code_of(rs[i])});
      end
    end
    $display("code table test done");
    load <= 8'd120;
    repeat (OCP - 10) @(posedge clk_sys_i);
    load <= 8'h00;
    `CHK(pwm_hiz_o, 1'b0)
    rd(12'h008, 32'h1);
    xfer(1'b1, 12'h008, 32'h1);
    load <= 8'd120;
    repeat (OCP + 10) @(posedge clk_sys_i);
    `CHK(pwm_hiz_o, 1'b1)
    `CHK(drv_on_o, 1'b0)
    `CHK(irq_o, 1'b0)
    rd(12'h008, 32'h5);
    xfer(1'b1, 12'h00C, 32'h7);
    repeat (2) @(posedge clk_sys_i);
    `CHK(irq_o, 1'b1)
    load <= 8'h00;
    repeat (6) @(posedge clk_sys_i);
    xfer(1'b1, 12'h008, 32'h7);
    repeat (2) @(posedge clk_sys_i);
    `CHK(irq_o, 1'b0)
    xfer(1'b1, 12'h00C, 32'h0);
    rd(12'h008, 32'h0);
    `CHK(pwm_hiz_o, 1'b1)
    start(4'hD);
    `CHK(pwm_hiz_o, 1'b0)
    load <= 8'd140;
    repeat (6) @(posedge clk_sys_i);
    `CHK(pwm_hiz_o, 1'b1)
    rd(12'h008, 32'h7);
    $display("overcurrent test done");
    test_done();
  end
endmodule
`default_nettype wire
